/* File: bench/pgr_host.sv */
// Behavioural model of the register controller that issues accesses to the bank.
`default_nettype none
module pgr_host
  import pgr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [7:0]        rdata,
  output var  pgr_pkg::pgr_req_t req,
  output var  logic              req_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    req = '0;
    req_valid = 1'b0;
  end

  // One access: a single valid cycle, then the released lines stop showing the old request.
  task automatic access(input logic wr, input logic remote, input logic [7:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rd);
    @(posedge clk);
    req <= '{wr: wr, remote: remote, addr: addr, wdata: wdata};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    req <= ~req;
    #1 rd = rdata;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the port and pin control register bank.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pgr_pkg::*;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rwd = 1'b0;
  logic det = 1'b0;
  logic [6:0] pins = 7'h00;
  pgr_rx_sts_t rx0 = '0;
  pgr_rx_sts_t rx1 = '0;
  pgr_req_t req;
  logic req_valid;
  logic [7:0] rdata;
  logic [1:0] ren;
  logic lock_o;
  logic pass_o;
  logic hv;
  logic [1:0] mode;
  logic [6:0] ien;
  logic p0;
  logic p0_oe;
  logic [2:0] p0_sel;
  logic [2:0] p0_src;
  int err_count = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  pgr_host i_host (.clk(clk), .rdata(rdata), .req(req), .req_valid(req_valid));

  pgr_regs #(.NPINS(7)) i_dut (
    .clk(clk), .nrst(nrst), .req(req), .req_valid(req_valid),
    .remote_write_disable(rwd), .rdata(rdata), .rx0_sts(rx0), .rx1_sts(rx1),
    .detected_3p3(det), .pin_in(7'h00), .pin_ext(pins), .receiver_enable(ren),
    .lock_out(lock_o), .pass_out(pass_o), .high_voltage_io_select(hv),
    .supply_mode(mode), .pin_input_enable(ien), .pin0_out(p0), .pin0_oe(p0_oe),
    .pin0_output_select(p0_sel), .pin0_output_source(p0_src));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic remote, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.access(1'b1, remote, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] x;
    i_host.access(1'b0, 1'b0, a, 8'h00, x);
    chk($sformatf("reg %h", a), exp, x);
  endtask

  // Reset values, with the detected supply low.
  task automatic t_reset();
    rd_chk(8'h0c, 8'h83);
    rd_chk(8'h0d, 8'h09);
    rd_chk(8'h0f, 8'h7f);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h20, 8'h00);
  endtask

  // Every indicator code with both receivers on, then with receiver 1 off.
  task automatic t_select();
    rx0 <= '{lock: 1'b1, pass: 1'b0};
    rx1 <= '{lock: 1'b0, pass: 1'b1};
    for (int c = 0; c < 4; c++)
    begin
      wr(1'b0, 8'h0c, 8'h03 | 8'(c << 4) | 8'(c << 2));
      chk("lock", 8'(4'h5 >> c) & 8'h01, {7'h0, lock_o});
      chk("pass", 8'(4'h6 >> c) & 8'h01, {7'h0, pass_o});
    end
    wr(1'b0, 8'h0c, 8'h29);
    chk("enable", 8'h01, {6'h0, ren});
    chk("pass any", 8'h00, {7'h0, pass_o});
    wr(1'b0, 8'h0c, 8'h3d);
    chk("lock all", 8'h01, {7'h0, lock_o});
  endtask

  // Remote writes: selects kept, then a remote write blocked by the disable while local writes still land.
  task automatic t_remote();
    wr(1'b1, 8'h0c, 8'h03);
    rd_chk(8'h0c, 8'hbf);
    rwd <= 1'b1;
    wr(1'b1, 8'h10, 8'h93);
    rd_chk(8'h10, 8'h00);
    wr(1'b0, 8'h0f, 8'h7e);
    chk("input enable", 8'h7e, {1'b0, ien});
    wr(1'b0, 8'h10, 8'h13);
    chk("pin0", 8'h11, {3'h0, p0_oe, 3'h0, p0});
    chk("pin0 fields", 8'h04, {2'h0, p0_sel, p0_src});
    rd_chk(8'h10, 8'h13);
    wr(1'b0, 8'h10, 8'h11);
    chk("pin0 low", 8'h10, {3'h0, p0_oe, 3'h0, p0});
    rwd <= 1'b0;
  endtask

  // Detected level against the override.
  task automatic t_supply();
    det <= 1'b1;
    rd_chk(8'h0d, 8'hb9);
    chk("supply", 8'h13, {3'h0, hv, 2'h0, mode});
    wr(1'b0, 8'h0d, 8'h40);
    rd_chk(8'h0d, 8'h49);
    chk("supply ov", 8'h00, {3'h0, hv, 2'h0, mode});
    // Detected level dropped, so only the override can raise the outputs.
    det <= 1'b0;
    wr(1'b0, 8'h0d, 8'hf0);
    chk("supply hi", 8'h13, {3'h0, hv, 2'h0, mode});
  endtask

  // Pin levels after the synchroniser; the status register ignores writes.
  task automatic t_status();
    pins <= 7'h55;
    repeat (3) @(posedge clk);
    rd_chk(8'h0e, 8'h55);
    wr(1'b0, 8'h0e, 8'hff);
    pins <= 7'h2a;
    repeat (3) @(posedge clk);
    rd_chk(8'h0e, 8'h2a);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_select();
    t_remote();
    t_supply();
    t_status();
    print_verdict();
  end

  // A hang is cut short well after the roughly 70 cycles the tests need.
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: logic/pgr_pkg.sv */
// Package holding the register map, field layout and types of the port/pin control bank.
`default_nettype none
package pgr_pkg;
  localparam logic [7:0] RECEIVER_PORT_CONTROL_ADDR = 8'h0c;
  localparam logic [7:0] IO_SUPPLY_CONTROL_ADDR     = 8'h0d;
  localparam logic [7:0] PIN_LEVEL_STATUS_ADDR      = 8'h0e;
  localparam logic [7:0] PIN_INPUT_ENABLE_ADDR      = 8'h0f;
  localparam logic [7:0] PIN0_OUTPUT_CONTROL_ADDR   = 8'h10;
  localparam int NUM_PINS = 7;
  // Reset values and reserved constants.
  localparam logic [1:0] RPC_RSVD_VAL       = 2'h2;
  localparam logic [1:0] RECEIVER_EN_RESET  = 2'h3;
  localparam logic [3:0] IOC_RSVD_VAL       = 4'h9;
  localparam logic [6:0] INPUT_EN_RESET     = 7'h7f;
  // Field positions.
  localparam int RPC_PASS_LSB = 4;
  localparam int RPC_LOCK_LSB = 2;
  localparam int IOC_SEL_BIT  = 7;
  localparam int IOC_OV_BIT   = 6;
  localparam int IOC_MODE_LSB = 4;
  localparam int P0_SEL_LSB   = 5;
  localparam int P0_SRC_LSB   = 2;
  localparam int P0_VAL_BIT   = 1;
  localparam int P0_EN_BIT    = 0;
  // Supply mode and pin source codes.
  localparam logic [1:0] MODE_1P8 = 2'h0;
  localparam logic [1:0] MODE_3P3 = 2'h3;
  localparam logic [2:0] SRC_REGISTER = 3'h4;
  localparam logic [2:0] SEL_REGISTER = 3'h0;
  // Indicator source selection codes shared by lock and pass.
  typedef enum logic [1:0] {
    PGR_SRC_PORT0 = 2'b00,
    PGR_SRC_PORT1 = 2'b01,
    PGR_SRC_ANY   = 2'b10,
    PGR_SRC_ALL   = 2'b11
  } pgr_src_t;
  // One register access from the I2C target logic.
  typedef struct packed {
    logic       wr;
    logic       remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgr_req_t;
  // Per-receiver status pair.
  typedef struct packed {
    logic lock;
    logic pass;
  } pgr_rx_sts_t;
endpackage
`default_nettype wire

/* File: logic/pgr_regs.sv */
// Port enable, indicator select, I/O supply and GPIO0 control register bank.
`default_nettype none
module pgr_regs
  import pgr_pkg::*;
#(
  parameter int NPINS = 7
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire pgr_pkg::pgr_req_t    req,
  input  wire logic                 req_valid,
  input  wire logic                 remote_write_disable,
  output logic [7:0]                rdata,
  input  wire pgr_pkg::pgr_rx_sts_t rx0_sts,
  input  wire pgr_pkg::pgr_rx_sts_t rx1_sts,
  input  wire logic                 detected_3p3,
  input  wire logic [NPINS-1:0]     pin_in,
  input  wire logic [NPINS-1:0]     pin_ext,
  output logic [1:0]                receiver_enable,
  output logic                      lock_out,
  output logic                      pass_out,
  output logic                      high_voltage_io_select,
  output logic [1:0]                supply_mode,
  output logic [NPINS-1:0]          pin_input_enable,
  output logic                      pin0_out,
  output logic                      pin0_oe,
  output logic [2:0]                pin0_output_select,
  output logic [2:0]                pin0_output_source
);
  import pgr_pkg::*;

  logic [1:0]       rx_en_q;
  logic [1:0]       pass_sel_q;
  logic [1:0]       lock_sel_q;
  logic             sel3_q;
  logic             ov_q;
  logic [1:0]       mode_q;
  logic [NPINS-1:0] in_en_q;
  logic [2:0]       out_sel_q;
  logic [2:0]       out_src_q;
  logic             out_val_q;
  logic             out_en_q;
  logic [NPINS-1:0] pin_sync;
  logic [7:0]       rdata_d;
  logic [7:0]       rdata_q;

  // Synchronised pin levels feed the status register.
  pgr_sync #(.WIDTH(NPINS)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (pin_ext),
    .dout (pin_sync)
  );

  // Write qualification: remote writes can be blocked wholesale, selects only local.
  wire wr_ok     = req_valid && req.wr && !(req.remote && remote_write_disable);
  wire wr_rpc    = wr_ok && (req.addr == RECEIVER_PORT_CONTROL_ADDR);
  wire wr_rpc_lc = wr_rpc && !req.remote;
  wire wr_ioc    = wr_ok && (req.addr == IO_SUPPLY_CONTROL_ADDR);
  wire wr_ien    = wr_ok && (req.addr == PIN_INPUT_ENABLE_ADDR);
  wire wr_p0     = wr_ok && (req.addr == PIN0_OUTPUT_CONTROL_ADDR);

  // Receiver port control register.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_en_q    <= RECEIVER_EN_RESET;
      pass_sel_q <= 2'h0;
      lock_sel_q <= 2'h0;
    end
    else
    begin
      if (wr_rpc)
        rx_en_q <= req.wdata[1:0];
      if (wr_rpc_lc)
      begin
        pass_sel_q <= req.wdata[RPC_PASS_LSB +: 2];
        lock_sel_q <= req.wdata[RPC_LOCK_LSB +: 2];
      end
    end
  end

  // I/O supply control register; reserved low nibble is not stored.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel3_q <= 1'b0;
      ov_q   <= 1'b0;
      mode_q <= MODE_1P8;
    end
    else if (wr_ioc)
    begin
      sel3_q <= req.wdata[IOC_SEL_BIT];
      ov_q   <= req.wdata[IOC_OV_BIT];
      mode_q <= req.wdata[IOC_MODE_LSB +: 2];
    end
  end

  // Pin input enables and GPIO0 output control.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_en_q   <= INPUT_EN_RESET;
      out_sel_q <= 3'h0;
      out_src_q <= 3'h0;
      out_val_q <= 1'b0;
      out_en_q  <= 1'b0;
    end
    else
    begin
      if (wr_ien)
        in_en_q <= req.wdata[NPINS-1:0];
      if (wr_p0)
      begin
        out_sel_q <= req.wdata[P0_SEL_LSB +: 3];
        out_src_q <= req.wdata[P0_SRC_LSB +: 3];
        out_val_q <= req.wdata[P0_VAL_BIT];
        out_en_q  <= req.wdata[P0_EN_BIT];
      end
    end
  end

  // Both receivers are looked at together; a disabled port never counts towards any or all, but the direct port codes still pass it.
  wire [1:0] lk_v = {rx1_sts.lock, rx0_sts.lock};
  wire [1:0] ps_v = {rx1_sts.pass, rx0_sts.pass};
  wire any_lock = |(lk_v & rx_en_q);
  wire all_lock = (rx_en_q != 2'h0) && ((lk_v & rx_en_q) == rx_en_q);
  wire any_pass = |(ps_v & rx_en_q);
  wire all_pass = (rx_en_q != 2'h0) && ((ps_v & rx_en_q) == rx_en_q);

  // Indicator selection.
  always_comb
  begin
    unique case (pgr_src_t'(lock_sel_q))
      PGR_SRC_PORT0: lock_out = rx0_sts.lock;
      PGR_SRC_PORT1: lock_out = rx1_sts.lock;
      PGR_SRC_ANY:   lock_out = any_lock;
      PGR_SRC_ALL:   lock_out = all_lock;
    endcase
    unique case (pgr_src_t'(pass_sel_q))
      PGR_SRC_PORT0: pass_out = rx0_sts.pass;
      PGR_SRC_PORT1: pass_out = rx1_sts.pass;
      PGR_SRC_ANY:   pass_out = any_pass;
      PGR_SRC_ALL:   pass_out = all_pass;
    endcase
  end

  // Effective supply controls: detected level unless override is set.
  wire [1:0] det_mode = detected_3p3 ? MODE_3P3 : MODE_1P8;
  assign high_voltage_io_select = ov_q ? sel3_q : detected_3p3;
  assign supply_mode            = ov_q ? mode_q : det_mode;

  // GPIO0 drive; other source codes belong to logic outside this bank, so pin_in is unused
  // altogether (the status path reads pin_ext) and the pin drives low for them.
  wire reg_src = (out_src_q == SRC_REGISTER) && (out_sel_q == SEL_REGISTER);
  assign pin0_out           = reg_src ? out_val_q : 1'b0;
  assign pin0_oe            = out_en_q;
  assign pin0_output_select = out_sel_q;
  assign pin0_output_source = out_src_q;
  assign receiver_enable    = rx_en_q;
  assign pin_input_enable   = in_en_q;

  // Read mux; reserved bits return their printed defaults.
  always_comb
  begin
    rdata_d = 8'h00;
    case (req.addr)
      RECEIVER_PORT_CONTROL_ADDR:
        rdata_d = {RPC_RSVD_VAL, pass_sel_q, lock_sel_q, rx_en_q};
      IO_SUPPLY_CONTROL_ADDR:
        rdata_d = {high_voltage_io_select, ov_q, supply_mode, IOC_RSVD_VAL};
      PIN_LEVEL_STATUS_ADDR:
        rdata_d = {1'b0, pin_sync};
      PIN_INPUT_ENABLE_ADDR:
        rdata_d = {1'b0, in_en_q};
      PIN0_OUTPUT_CONTROL_ADDR:
        rdata_d = {out_sel_q, out_src_q, out_val_q, out_en_q};
      default:
        rdata_d = 8'h00;
    endcase
  end

  // Read data is registered one cycle after the address is presented.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else if (req_valid && !req.wr)
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

  // Assertions.
  property p_lock_all;
    @(posedge clk) disable iff (!nrst)
      (lock_sel_q == 2'h3 && rx_en_q == 2'h3) |-> (lock_out == (rx0_sts.lock && rx1_sts.lock));
  endproperty
  a_lock_all: assert property (p_lock_all) else $error("lock all mismatch");

  property p_pass_any;
    @(posedge clk) disable iff (!nrst)
      (pass_sel_q == 2'h2) |-> (pass_out == |(ps_v & rx_en_q));
  endproperty
  a_pass_any: assert property (p_pass_any) else $error("pass any mismatch");

  property p_remote_sel;
    @(posedge clk) disable iff (!nrst)
      (req_valid && req.wr && req.remote && req.addr == RECEIVER_PORT_CONTROL_ADDR)
        |=> $stable(lock_sel_q) && $stable(pass_sel_q);
  endproperty
  a_remote_sel: assert property (p_remote_sel) else $error("remote wrote select");

  property p_rx_en_wr;
    @(posedge clk) disable iff (!nrst)
      (wr_rpc) |=> (rx_en_q == $past(req.wdata[1:0]));
  endproperty
  a_rx_en_wr: assert property (p_rx_en_wr) else $error("receiver enable not written");

  property p_detected;
    @(posedge clk) disable iff (!nrst)
      !ov_q |-> (high_voltage_io_select == detected_3p3) && (supply_mode == det_mode);
  endproperty
  a_detected: assert property (p_detected) else $error("detected level not used");

  property p_status_rd;
    @(posedge clk) disable iff (!nrst)
      (req_valid && !req.wr && req.addr == PIN_LEVEL_STATUS_ADDR) |=> (rdata[7] == 1'b0);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status bit 7 set");

  property p_sync_lat;
    @(posedge clk) disable iff (!nrst)
      ##2 (pin_sync == $past(pin_ext, 2));
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("synchroniser latency wrong");

  property p_remote_block;
    @(posedge clk) disable iff (!nrst)
      (req_valid && req.wr && req.remote && remote_write_disable
        && req.addr == PIN0_OUTPUT_CONTROL_ADDR) |=> $stable(out_en_q) && $stable(out_val_q);
  endproperty
  a_remote_block: assert property (p_remote_block) else $error("remote write leaked");

  property p_reg_drive;
    @(posedge clk) disable iff (!nrst)
      (out_src_q == 3'h4 && out_sel_q == 3'h0) |-> (pin0_out == out_val_q);
  endproperty
  a_reg_drive: assert property (p_reg_drive) else $error("pin0 not driven from value bit");
endmodule
`default_nettype wire

/* File: logic/pgr_sync.sv */
// Two-stage synchroniser for a vector of pin levels.
`default_nettype none
module pgr_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second, so metastability has a cycle to settle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire
